// file: rtl/rsse_addr.v
// Operand address resolution: access bank, banked and indexed literal offset
`timescale 1ns/10ps
`default_nettype none
`include "rsse_map.vh"

module rsse_addr #(
   parameter AW = 12
) (
   input  wire [7:0]      fsel,
   input  wire            acc_n,
   input  wire [AW-9:0]   bank,
   input  wire            ext_en,
   input  wire [AW-1:0]   idx_base,
   output reg  [AW-1:0]   addr
);
   wire low_half = (fsel <= `RSSE_ACC_LIMIT);

   // Access bank splits into low memory and the top special area
   always @* begin
      if (acc_n) begin
         addr = {bank, fsel};
      end else if (ext_en && low_half) begin
         addr = idx_base + {{(AW-8){1'b0}}, fsel};
      end else if (low_half) begin
         addr = {{(AW-8){1'b0}}, fsel};
      end else begin
         addr = {{(AW-8){1'b1}}, fsel};
      end
   end
endmodule

`default_nettype wire

// file: rtl/rsse_alu.v
// Subtract and rotate datapath with status flag generation
`timescale 1ns/10ps
`default_nettype none
`include "rsse_map.vh"

module rsse_alu (
   input  wire [7:0] opa,
   input  wire [7:0] opb,
   input  wire       no_borrow,
   input  wire       rot_en,
   output reg  [7:0] res,
   output reg  [4:0] flags
);
   reg [8:0] full;
   reg [4:0] low;

   // Subtract as a + ~b + carry, so the carry comes out as inverted borrow
   always @* begin
      full = {1'b0, opa} + {1'b0, ~opb} + {8'h00, no_borrow};
      low = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + {4'h0, no_borrow};
      flags = 5'h00;
      if (rot_en) begin
         res = {opa[0], opa[7:1]};
      end else begin
         res = full[7:0];
         flags[`RSSE_ST_C] = full[8];
         flags[`RSSE_ST_DC] = low[4];
         flags[`RSSE_ST_OV] = (opa[7] ^ opb[7]) & (full[7] ^ opa[7]);
      end
      flags[`RSSE_ST_N] = res[7];
      flags[`RSSE_ST_Z] = (res == 8'h00);
   end
endmodule

`default_nettype wire

// file: rtl/rsse_core.v
// Executor for rotate, set, sleep and subtract instructions with APB access
`timescale 1ns/10ps
`default_nettype none
`include "rsse_map.vh"

module rsse_core #(
   parameter AW       = 12,
   parameter WDT_TICK = `RSSE_WDT_TICK_CYC,
   parameter POST_W   = 4
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         osc_stop
);
   // Instruction classes and phases
   localparam [2:0] CL_ILL  = 3'd0;
   localparam [2:0] CL_RR   = 3'd1;
   localparam [2:0] CL_SET  = 3'd2;
   localparam [2:0] CL_SLP  = 3'd3;
   localparam [2:0] CL_SFWB = 3'd4;
   localparam [2:0] CL_SLW  = 3'd5;
   localparam [2:0] CL_SWF  = 3'd6;
   localparam [1:0] PH_Q1   = 2'd0;
   localparam [1:0] PH_Q2   = 2'd1;
   localparam [1:0] PH_Q3   = 2'd2;
   localparam [1:0] PH_Q4   = 2'd3;
   // Cut to the divider width on purpose; the tick period fits in 16 bits
   localparam integer TICK_LAST_I = WDT_TICK - 1;
   localparam [15:0]  TICK_LAST   = TICK_LAST_I[15:0];
   // Postscaler step, built without a zero-width replication when POST_W is 1
   localparam [POST_W:0] POST_ONE = {{POST_W{1'b0}}, 1'b1};

   reg  [7:0]        mem [0:(1<<AW)-1];
   reg  [1:0]        ctrl_q;
   reg  [15:0]       instr_q;
   reg  [4:0]        flags_q;
   reg  [7:0]        wacc_q;
   reg  [AW-9:0]     bank_q;
   reg  [AW-1:0]     idxb_q;
   reg  [AW-1:0]     daddr_q;
   reg               busy_q;
   reg  [1:0]        phase_q;
   reg  [2:0]        class_q;
   reg               ill_q;
   reg  [AW-1:0]     addr_q;
   reg  [7:0]        opnd_q;
   reg  [7:0]        res_q;
   reg  [4:0]        rflags_q;
   reg               to_q;
   reg               pd_q;
   reg  [7:0]        wdt_cnt_q;
   reg  [POST_W-1:0] wdt_post_q;
   reg  [15:0]       tick_q;
   reg               wdt_to_q;
   reg  [31:0]       rd_d;
   reg               err_d;
   wire [AW-1:0]     res_addr;
   wire [7:0]        alu_res;
   wire [4:0]        alu_flags;

   // Opcode field match to instruction class
   function [2:0] op_class;
      input [15:0] op;
      begin
         if (op[15:10] == 6'b010000) op_class = CL_RR;
         else if (op[15:9] == 7'b0110100) op_class = CL_SET;
         else if (op == `RSSE_OP_SLEEP) op_class = CL_SLP;
         else if (op[15:10] == 6'b010101) op_class = CL_SFWB;
         else if (op[15:8] == 8'h08) op_class = CL_SLW;
         else if (op[15:10] == 6'b010111) op_class = CL_SWF;
         else op_class = CL_ILL;
      end
   endfunction

   wire setup   = psel & ~penable;
   wire wr      = psel & penable & pready & pwrite & ~pslverr;
   wire start   = wr && (paddr == `RSSE_OFF_INSTR);
   wire q4      = busy_q && (phase_q == PH_Q4);
   wire has_d   = (class_q == CL_RR) || (class_q == CL_SFWB) || (class_q == CL_SWF);
   wire is_sub  = (class_q == CL_SFWB) || (class_q == CL_SLW) || (class_q == CL_SWF);
   wire dest_w  = (class_q == CL_SLW) || (has_d && !instr_q[9]);
   wire dest_f  = (class_q == CL_SET) || (has_d && instr_q[9]);
   wire sfwb    = (class_q == CL_SFWB);
   wire tick    = (tick_q == TICK_LAST);
   wire wdt_top = (wdt_cnt_q == 8'hff) && (&wdt_post_q);

   rsse_addr #(
      .AW(AW)
   ) u_addr (
      .fsel     (instr_q[7:0]),
      .acc_n    (instr_q[8]),
      .bank     (bank_q),
      .ext_en   (ctrl_q[`RSSE_CTRL_EXT]),
      .idx_base (idxb_q),
      .addr     (res_addr)
   );

   // Borrow form takes W as the minuend and the carry flag as no-borrow; the others subtract W with no borrow
   rsse_alu u_alu (
      .opa       (sfwb ? wacc_q : opnd_q),
      .opb       (sfwb ? opnd_q : wacc_q),
      .no_borrow (sfwb ? flags_q[`RSSE_ST_C] : 1'b1),
      .rot_en    (class_q == CL_RR),
      .res       (alu_res),
      .flags     (alu_flags)
   );

   // Read mux and refusal decode during the setup phase
   always @* begin
      rd_d = 32'h0;
      err_d = 1'b0;
      if (paddr == `RSSE_OFF_CTRL) begin
         rd_d[1:0] = ctrl_q;
      end else if (paddr == `RSSE_OFF_INSTR) begin
         rd_d[15:0] = instr_q;
         err_d = pwrite & (busy_q | osc_stop);
      end else if (paddr == `RSSE_OFF_STATUS) begin
         rd_d[4:0] = flags_q;
         err_d = pwrite & busy_q;
      end else if (paddr == `RSSE_OFF_CORE) begin
         rd_d[4:0] = {ill_q, pd_q, to_q, osc_stop, busy_q};
      end else if (paddr == `RSSE_OFF_WACC) begin
         rd_d[7:0] = wacc_q;
         err_d = pwrite & busy_q;
      end else if (paddr == `RSSE_OFF_BANK) begin
         rd_d[AW-9:0] = bank_q;
         err_d = pwrite & busy_q;
      end else if (paddr == `RSSE_OFF_IDXB) begin
         rd_d[AW-1:0] = idxb_q;
         err_d = pwrite & busy_q;
      end else if (paddr == `RSSE_OFF_DADDR) begin
         rd_d[AW-1:0] = daddr_q;
      end else if (paddr == `RSSE_OFF_DDATA) begin
         rd_d[7:0] = mem[daddr_q];
         err_d = pwrite & busy_q;
      end else if (paddr == `RSSE_OFF_WDOG) begin
         rd_d[8+POST_W-1:0] = {wdt_post_q, wdt_cnt_q};
      end else begin
         err_d = 1'b1;
      end
   end

   // Zero wait state answer, registered so outputs come from flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setup;
         pslverr <= setup & err_d;
         prdata <= (setup & ~pwrite) ? rd_d : 32'h0;
      end
   end

   // Software owned configuration registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `RSSE_CTRL_RST;
         bank_q <= {(AW-8){1'b0}};
         idxb_q <= {AW{1'b0}};
         daddr_q <= {AW{1'b0}};
      end else if (wr) begin
         if (paddr == `RSSE_OFF_CTRL) ctrl_q <= pwdata[1:0];
         if (paddr == `RSSE_OFF_BANK) bank_q <= pwdata[AW-9:0];
         if (paddr == `RSSE_OFF_IDXB) idxb_q <= pwdata[AW-1:0];
         if (paddr == `RSSE_OFF_DADDR) daddr_q <= pwdata[AW-1:0];
      end
   end

   // Four phase sequencer, one clock per phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_q <= 16'h0000;
         busy_q <= 1'b0;
         phase_q <= PH_Q1;
         class_q <= CL_ILL;
         ill_q <= 1'b0;
         addr_q <= {AW{1'b0}};
         opnd_q <= 8'h00;
         res_q <= 8'h00;
         rflags_q <= 5'h00;
      end else if (start) begin
         instr_q <= pwdata[15:0];
         busy_q <= 1'b1;
         phase_q <= PH_Q1;
      end else if (busy_q) begin
         case (phase_q)
            PH_Q1: begin
               class_q <= op_class(instr_q);
               ill_q <= (op_class(instr_q) == CL_ILL);
               addr_q <= res_addr;
               phase_q <= PH_Q2;
            end
            PH_Q2: begin
               // Literal form takes the immediate byte, not memory
               opnd_q <= (class_q == CL_SLW) ? instr_q[7:0] : mem[addr_q];
               phase_q <= PH_Q3;
            end
            PH_Q3: begin
               res_q <= (class_q == CL_SET) ? `RSSE_ALL_ONES : alu_res;
               rflags_q <= alu_flags;
               phase_q <= PH_Q4;
            end
            default: begin
               busy_q <= 1'b0;
               phase_q <= PH_Q1;
            end
         endcase
      end
   end

   // Accumulator: software write, or result when destination is W
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wacc_q <= `RSSE_WACC_RST;
      end else if (q4 && dest_w) begin
         wacc_q <= res_q;
      end else if (wr && (paddr == `RSSE_OFF_WACC)) begin
         wacc_q <= pwdata[7:0];
      end
   end

   // Status flags; rotate keeps carry, set keeps all
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= `RSSE_FLAGS_RST;
      end else if (q4 && (class_q == CL_RR)) begin
         flags_q[`RSSE_ST_N] <= rflags_q[`RSSE_ST_N];
         flags_q[`RSSE_ST_Z] <= rflags_q[`RSSE_ST_Z];
      end else if (q4 && is_sub) begin
         flags_q <= rflags_q;
      end else if (wr && (paddr == `RSSE_OFF_STATUS)) begin
         flags_q <= pwdata[4:0];
      end
   end

   // Data memory has no reset; Q4 write and APB write never overlap
   always @(posedge pclk) begin
      if (q4 && dest_f) begin
         mem[addr_q] <= res_q;
      end else if (wr && (paddr == `RSSE_OFF_DDATA)) begin
         mem[daddr_q] <= pwdata[7:0];
      end
   end

   // Sleep entry in the last phase; watchdog time out wakes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_stop <= 1'b0;
         to_q <= `RSSE_TO_RST;
         pd_q <= `RSSE_PD_RST;
      end else if (q4 && (class_q == CL_SLP)) begin
         osc_stop <= 1'b1;
         pd_q <= 1'b0;
         to_q <= 1'b1;
      end else if (wdt_to_q) begin
         osc_stop <= 1'b0;
         to_q <= 1'b0;
      end
   end

   // Watchdog tick divider, runs on its own while the core sleeps
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= 16'h0000;
      end else if (tick) begin
         tick_q <= 16'h0000;
      end else begin
         tick_q <= tick_q + 16'h0001;
      end
   end

   // Watchdog counter and postscaler; sleep entry restarts them
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_cnt_q <= 8'h00;
         wdt_post_q <= {POST_W{1'b0}};
         wdt_to_q <= 1'b0;
      end else if (q4 && (class_q == CL_SLP)) begin
         wdt_cnt_q <= 8'h00;
         wdt_post_q <= {POST_W{1'b0}};
         wdt_to_q <= 1'b0;
      end else if (ctrl_q[`RSSE_CTRL_WDEN] && tick) begin
         wdt_cnt_q <= wdt_cnt_q + 8'h01;
         if (wdt_cnt_q == 8'hff) begin
            wdt_post_q <= wdt_post_q + POST_ONE[POST_W-1:0];
         end
         wdt_to_q <= wdt_top;
      end else begin
         wdt_to_q <= 1'b0;
      end
   end
endmodule

`default_nettype wire

// file: rtl/rsse_map.vh
// Register offsets, field positions, reset values and timing counts of the executor
`ifndef RSSE_MAP_VH
`define RSSE_MAP_VH

// Register byte offsets on the APB port
`define RSSE_OFF_CTRL   8'h00
`define RSSE_OFF_INSTR  8'h04
`define RSSE_OFF_STATUS 8'h08
`define RSSE_OFF_CORE   8'h0c
`define RSSE_OFF_WACC   8'h10
`define RSSE_OFF_BANK   8'h14
`define RSSE_OFF_IDXB   8'h18
`define RSSE_OFF_DADDR  8'h1c
`define RSSE_OFF_DDATA  8'h20
`define RSSE_OFF_WDOG   8'h24

// Control register fields
`define RSSE_CTRL_EXT   0
`define RSSE_CTRL_WDEN  1

// Status flag positions
`define RSSE_ST_C       0
`define RSSE_ST_DC      1
`define RSSE_ST_Z       2
`define RSSE_ST_OV      3
`define RSSE_ST_N       4

// Core state register fields
`define RSSE_CORE_BUSY  0
`define RSSE_CORE_SLEEP 1
`define RSSE_CORE_TO    2
`define RSSE_CORE_PD    3
`define RSSE_CORE_ILL   4

// Reset values
`define RSSE_CTRL_RST   2'h0
`define RSSE_FLAGS_RST  5'h00
`define RSSE_WACC_RST   8'h00
`define RSSE_TO_RST     1'b1
`define RSSE_PD_RST     1'b1

// Operand and opcode constants
`define RSSE_ACC_LIMIT  8'h5f
`define RSSE_ALL_ONES   8'hff
`define RSSE_OP_SLEEP   16'h0003

// Watchdog tick period in core clocks
`define RSSE_WDT_TICK_CYC 100

`endif

// file: testbench/rsse_apb_mst.sv
// APB master model standing in for the fetch side and software
`timescale 1ns/10ps
`default_nettype none
module rsse_apb_mst (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic tmo;
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tmo = 1'b0;
   end
   // One transfer, request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n == 20) tmo = 1'b1;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: testbench/rsse_checker.sv
// Port-level checks of the executor's APB answers and sleep output
`timescale 1ns/10ps
`default_nettype none
module rsse_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        osc_stop
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Every setup is answered in the very next cycle
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   ready_in_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
      else $error("pready outside access cycle");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready stood too long");
   // Read data is zero outside the access cycle
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero while idle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // Addresses above the last register are refused
   unmapped_err_a: assert property (psel && !penable && paddr > 8'h24 |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   core_upper_a: assert property (pready && !pwrite && paddr == 8'h0c |-> prdata[31:5] == 27'h0)
      else $error("core state upper bits set");
   // Wake needs hundreds of ticks, so a short sleep is a fault
   sleep_holds_a: assert property ($rose(osc_stop) |-> osc_stop [*8])
      else $error("sleep ended too soon");
endmodule
bind rsse_core rsse_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .osc_stop);
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the rotate, set, sleep and subtract executor
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   wire         psel, penable, pwrite, pready, pslverr, osc_stop;
   wire [7:0]   paddr;
   wire [31:0]  pwdata, prdata;
   int          fail_count = 0;
   int          checked = 0;

   always #5 pclk = ~pclk;

   // Short watchdog so a wake from sleep takes about a thousand clocks
   rsse_core #(.WDT_TICK(2), .POST_W(1)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_stop(osc_stop));
   rsse_apb_mst m_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task test_done;
      if (m_u.tmo) fail_count++;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      m_u.xfer(1'b1, a, d, q, e);
      chk("write error", 32'(e), 32'h0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] q;
      logic        e;
      m_u.xfer(1'b0, a, 32'h0, q, e);
      chk(nm, q, exp);
   endtask
   task mem_wr(input logic [11:0] a, input logic [7:0] v);
      wr(8'h1c, 32'(a));
      wr(8'h20, 32'(v));
   endtask
   task mem_chk(input logic [11:0] a, input logic [7:0] v);
      wr(8'h1c, 32'(a));
      rd(8'h20, 32'(v), "memory byte");
   endtask
   // Issue one opcode and poll the busy bit, bounded
   task exec(input logic [15:0] op);
      logic [31:0] q;
      logic        e;
      int          n;
      wr(8'h04, {16'h0, op});
      n = 0;
      q = 32'h1;
      while (q[0] !== 1'b0 && n < 10) begin
         m_u.xfer(1'b0, 8'h0c, 32'h0, q, e);
         n++;
      end
      chk("busy", 32'(q[0]), 32'h0);
      if (n == 10) test_done();
   endtask
   // Expected {N,OV,Z,DC,C, result} of a - b - !ci
   function automatic logic [12:0] sub_exp(input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [8:0] s;
      logic [4:0] lo;
      s = {1'b0, a} + {1'b0, ~b} + 9'(ci);
      lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(ci);
      return {s[7], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, lo[4], s[8], s[7:0]};
   endfunction

   task t_reset;
      logic [31:0] q;
      logic        e;
      rd(8'h00, 32'h0, "control");
      rd(8'h08, 32'h0, "status");
      rd(8'h10, 32'h0, "accumulator");
      rd(8'h0c, 32'h0c, "core state");
      m_u.xfer(1'b0, 8'h28, 32'h0, q, e);
      chk("unmapped error", {q[30:0], e}, 32'h1);
      // A second opcode while busy is refused; an unknown opcode only marks ill
      wr(8'h04, 32'hffff);
      m_u.xfer(1'b1, 8'h04, 32'h4210, q, e);
      chk("busy refusal", 32'(e), 32'h1);
      exec(16'hffff);
      rd(8'h0c, 32'h1c, "illegal opcode");
   endtask
   // Rotate right: both destinations and a zero result
   task t_rot;
      mem_wr(12'h010, 8'hd7);
      wr(8'h08, 32'h1f);
      exec(16'h4210);
      mem_chk(12'h010, 8'heb);
      rd(8'h08, 32'h1b, "rotate flags");
      exec(16'h4010);
      rd(8'h10, 32'hf5, "rotate to acc");
      mem_chk(12'h010, 8'heb);
      mem_wr(12'h010, 8'h00);
      wr(8'h08, 32'h00);
      exec(16'h4210);
      rd(8'h08, 32'h04, "zero flag");
   endtask
   // Set all ones through banked and access addressing
   task t_set_register_all_ones_op;
      wr(8'h14, 32'h3);
      mem_wr(12'h322, 8'h5a);
      mem_wr(12'hf70, 8'h00);
      wr(8'h08, 32'h15);
      exec(16'h6922);
      mem_chk(12'h322, 8'hff);
      rd(8'h08, 32'h15, "set flags");
      exec(16'h6870);
      mem_chk(12'hf70, 8'hff);
      wr(8'h00, 32'h1);
      wr(8'h18, 32'h200);
      mem_wr(12'h205, 8'h00);
      mem_wr(12'h005, 8'h11);
      exec(16'h6805);
      mem_chk(12'h205, 8'hff);
      mem_chk(12'h005, 8'h11);
      wr(8'h00, 32'h0);
   endtask
   // kind 0 borrow form, 1 register minus acc, 2 literal minus acc
   task sub_case(input int kind, input logic [7:0] w, input logic [7:0] fv, input logic ci, input logic d);
      logic [12:0] ex;
      logic [15:0] op;
      ex = (kind == 0) ? sub_exp(w, fv, ci) : sub_exp(fv, w, 1'b1);
      op = (kind == 0) ? 16'h5400 : (kind == 1) ? 16'h5c00 : {8'h08, fv};
      if (kind < 2) op = op | {6'h0, d, 9'h030};
      mem_wr(12'h030, fv);
      wr(8'h10, 32'(w));
      wr(8'h08, 32'(ci));
      exec(op);
      rd(8'h10, 32'((kind == 2 || !d) ? ex[7:0] : w), "sub acc");
      mem_chk(12'h030, (kind < 2 && d) ? ex[7:0] : fv);
      rd(8'h08, 32'(ex[12:8]), "sub flags");
   endtask
   // Sleep, then wake only by watchdog wrap
   task t_sleep;
      logic [31:0] q;
      logic        e;
      int          n;
      wr(8'h00, 32'h2);
      // Let the watchdog run well past the post-sleep bound so clearing shows
      repeat (100) @(posedge pclk);
      m_u.xfer(1'b0, 8'h24, 32'h0, q, e);
      chk("watchdog running", 32'(q > 32'h20), 32'h1);
      exec(16'h0003);
      chk("oscillator stopped", 32'(osc_stop), 32'h1);
      rd(8'h0c, 32'h06, "sleep state");
      m_u.xfer(1'b0, 8'h24, 32'h0, q, e);
      chk("watchdog cleared", 32'(q < 32'h10), 32'h1);
      m_u.xfer(1'b1, 8'h04, 32'h0003, q, e);
      chk("sleep refusal", 32'(e), 32'h1);
      n = 0;
      while (osc_stop !== 1'b0 && n < 1500) begin
         @(posedge pclk);
         n++;
      end
      chk("wake late", 32'(n > 900 && n < 1500), 32'h1);
      if (n == 1500) test_done();
      rd(8'h0c, 32'h00, "woken state");
   endtask

   initial begin
      #500000;
      fail_count++;
      test_done();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_rot();
      t_set_register_all_ones_op();
      sub_case(0, 8'h02, 8'h03, 1'b1, 1'b1);
      sub_case(0, 8'h05, 8'h02, 1'b1, 1'b0);
      sub_case(0, 8'h02, 8'h01, 1'b0, 1'b1);
      sub_case(1, 8'h02, 8'h03, 1'b0, 1'b1);
      sub_case(1, 8'h02, 8'h02, 1'b0, 1'b0);
      sub_case(1, 8'h01, 8'h80, 1'b1, 1'b1);
      sub_case(2, 8'h03, 8'h02, 1'b1, 1'b0);
      sub_case(2, 8'h01, 8'h02, 1'b0, 1'b1);
      t_sleep();
      test_done();
   end
endmodule
`default_nettype wire
